// ### inc/vcwu_pkg.sv
package vcwu_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] VCWU_OFS_DEMC = 12'h000; // Control register
  localparam logic [11:0] VCWU_OFS_HALT = 12'h004; // Halting control status
  localparam logic [11:0] VCWU_OFS_DEBUG_FAULT_STATUS = 12'h008; // Fault status, write one clears
  localparam logic [11:0] VCWU_OFS_WCTL = 12'h010; // Watch unit control
  localparam logic [11:0] VCWU_OFS_CMP0 = 12'h020; // First comparator reference
  localparam logic [11:0] VCWU_CMP_STRIDE = 12'h010; // Spacing of comparator sets
  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int VCWU_BIT_WEN = 24; // Watch unit global enable
  localparam int VCWU_BIT_VCHF = 10; // Hard fault catch enable
  localparam int VCWU_BIT_VCRST = 0; // Local reset catch enable
  localparam int VCWU_NUM_POS = 28; // Comparator count field
  localparam logic [31:0] VCWU_DEMC_RST = 32'h0000_0000;
  localparam logic [31:0] VCWU_DEMC_MASK = 32'h0100_0401;
  localparam int VCWU_FS_VCATCH = 3; // Fault status catch bit
  localparam int VCWU_FS_WATCH = 2; // Fault status watch bit
  localparam logic [3:0] VCWU_FN_OFF = 4'h0;
  localparam logic [3:0] VCWU_FN_PC = 4'h4;
  localparam logic [3:0] VCWU_FN_RD = 4'h5;
  localparam logic [3:0] VCWU_FN_WR = 4'h6;
  localparam logic [3:0] VCWU_FN_RW = 4'h7;
endpackage

// ### logic/vcwu_top.sv
`timescale 1ns/100ps
`default_nettype none
module vcwu_top #(
  parameter int NCOMP = 2, // Comparator sets
  parameter int MAXMASK = 31 // Widest supported mask
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic local_reset, // Core local reset pulse
  input wire logic hard_fault_active, // Hard fault became active
  input wire logic handler_first, // Core at first handler instruction
  input wire logic entry_busy, // Late or derived exception in entry
  input wire logic iaddr_valid,
  input wire logic [31:0] iaddr,
  input wire logic daddr_valid,
  input wire logic daddr_write,
  input wire logic [1:0] daddr_size, // 0 byte, 1 half, 2 word
  input wire logic [31:0] daddr,
  input wire logic core_halted,
  output logic halt_request, // Core halt request level
  output logic [31:0] watch_match // Per-comparator hit, registered
);
  // ----------------------------------------
  // Overview
  // ----------------------------------------
  // The block sits beside the core and watches two things.
  // Vector catch turns a hard fault or a local reset into a halt.
  // The comparators turn a matching address into a halt.
  // Both paths meet in one halt request level.
  // The request stands until the core reports Debug state.
  // Software reaches everything over a zero wait state bus.
  // Reads are latched in the setup cycle of a transfer.
  // Writes land at the access edge of a transfer.
  // Unmapped offsets raise an error and change nothing.
  // Core side inputs share the bus clock, so none is synchronised.
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Register map, byte offsets:
  // 0x000 exception and monitor control
  // 0x004 halting control, bit 0 enables halting debug
  // 0x008 fault status, write one to clear
  // 0x010 watch unit control, comparator count on top
  // 0x020 first comparator reference
  // 0x024 first comparator mask size
  // 0x028 first comparator function
  // Each further comparator follows sixteen bytes on
  // Limitations:
  // Byte and halfword bus accesses are not supported
  // Only word aligned offsets decode, except comparator offsets, whose low two bits are ignored
  // No comparator data value matching is offered
  // No cycle counting or trace output is offered
  // The sample register is outside this block
  // Write strobe is valid for exactly one edge per transfer
  // Read capture uses the setup cycle so data stands at access
  // Comparator decode covers reference, mask and function words
  // The fourth word of each comparator set is left unmapped
  wire wr_en = psel && penable && pwrite;
  wire rd_phase = psel && !penable;
  wire sel_demc = paddr == vcwu_pkg::VCWU_OFS_DEMC;
  wire sel_halt = paddr == vcwu_pkg::VCWU_OFS_HALT;
  wire sel_debug_fault_status = paddr == vcwu_pkg::VCWU_OFS_DEBUG_FAULT_STATUS;
  wire sel_wctl = paddr == vcwu_pkg::VCWU_OFS_WCTL;
  wire [11:0] cmp_off = paddr - vcwu_pkg::VCWU_OFS_CMP0;
  wire [7:0] cmp_idx = cmp_off[11:4];
  wire sel_cmp = paddr >= vcwu_pkg::VCWU_OFS_CMP0 && int'(cmp_idx) < NCOMP && cmp_off[3:2] != 2'b11;
  wire mapped = sel_demc || sel_halt || sel_debug_fault_status || sel_wctl || sel_cmp;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Only the three documented control bits are kept
  // Reserved bits are dropped at the write mask
  // A catch is armed only while halting debug is on
  // Each armed catch looks at its own exception event
  logic [31:0] demc_q; // Exception and monitor control
  logic debug_en_q; // Halting debug enable
  logic [3:0] fsr_q; // Debug fault status
  logic catch_pend_q; // Vector catch waiting for handler
  logic halt_q; // Halt request
  wire halt_dbg_bit = pwdata[0];
  wire [31:0] demc_wr = pwdata & vcwu_pkg::VCWU_DEMC_MASK;
  wire watch_on = demc_q[vcwu_pkg::VCWU_BIT_WEN];
  wire arm_hf = debug_en_q && demc_q[vcwu_pkg::VCWU_BIT_VCHF];
  wire arm_rst = debug_en_q && demc_q[vcwu_pkg::VCWU_BIT_VCRST];
  wire catch_ev = (arm_hf && hard_fault_active) || (arm_rst && local_reset);

  // Control register: power-on clears all, local reset clears enable only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demc_q <= vcwu_pkg::VCWU_DEMC_RST;
    end else if (wr_en && sel_demc) begin
      demc_q <= demc_wr;
    end else if (local_reset) begin
      demc_q[vcwu_pkg::VCWU_BIT_WEN] <= 1'b0;
    end
  end

  // Halting debug enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_en_q <= 1'b0;
    end else if (wr_en && sel_halt) begin
      debug_en_q <= halt_dbg_bit;
    end
  end

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  // Each set holds a reference, a mask size and a function
  // Writes are refused while the watch unit is disabled
  // The mask clears low address bits before comparing
  // Mask sizes above the supported limit are clamped
  // Data matches align the reference to the access size
  // Reserved function codes never produce a match
  // Instruction matches use the fetch address strobe
  // Data matches use the access strobe and direction
  logic [31:0] comp_q [NCOMP]; // Reference values
  logic [4:0] mask_q [NCOMP]; // Masked low bit count
  logic [3:0] func_q [NCOMP]; // Match type
  logic [NCOMP-1:0] hit;
  wire [4:0] mask_lim = 5'(MAXMASK);

  for (genvar n = 0; n < NCOMP; n++) begin : g_cmp
    wire wsel = wr_en && sel_cmp && watch_on && int'(cmp_idx) == n;
    wire [4:0] msz = (mask_q[n] > mask_lim) ? mask_lim : mask_q[n];
    wire [31:0] amask = ~((32'h0000_0001 << msz) - 32'h0000_0001);
    wire [31:0] dcmp = daddr_size == 2'd2 ? {comp_q[n][31:2], 2'b00} :
                       daddr_size == 2'd1 ? {comp_q[n][31:1], 1'b0} : comp_q[n];
    wire f_pc = func_q[n] == vcwu_pkg::VCWU_FN_PC;
    wire f_d = (func_q[n] == vcwu_pkg::VCWU_FN_RD && !daddr_write) ||
               (func_q[n] == vcwu_pkg::VCWU_FN_WR && daddr_write) ||
               func_q[n] == vcwu_pkg::VCWU_FN_RW;
    assign hit[n] = watch_on && ((f_pc && iaddr_valid && (iaddr & amask) == comp_q[n]) ||
                    (f_d && daddr_valid && (daddr & amask) == dcmp));
    // Comparator set registers
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        comp_q[n] <= 32'h0000_0000;
        mask_q[n] <= 5'h00;
        func_q[n] <= vcwu_pkg::VCWU_FN_OFF;
      end else if (wsel && cmp_off[3:2] == 2'd0) begin
        comp_q[n] <= pwdata;
      end else if (wsel && cmp_off[3:2] == 2'd1) begin
        mask_q[n] <= pwdata[4:0];
      end else if (wsel && cmp_off[3:2] == 2'd2) begin
        func_q[n] <= pwdata[3:0];
      end
    end
  end
  wire watch_ev = |hit;

  // ----------------------------------------
  // Halt and fault status
  // ----------------------------------------
  // A catch is first held pending until the handler is reached
  // Late or derived exceptions hold the pending catch back
  // A watch hit raises the halt request on the next edge
  // The core drops the request by reporting Debug state
  // Status bits record the source of each halt for software
  // Catch waits for the handler's first instruction and for a quiet entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      catch_pend_q <= 1'b0;
    end else if (catch_ev) begin
      catch_pend_q <= 1'b1;
    end else if (handler_first && !entry_busy) begin
      catch_pend_q <= 1'b0;
    end
  end
  wire catch_go = catch_pend_q && handler_first && !entry_busy;

  // Halt request holds until core reports halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (catch_go || watch_ev) begin
      halt_q <= 1'b1;
    end else if (core_halted) begin
      halt_q <= 1'b0;
    end
  end
  assign halt_request = halt_q;

  // Status bits: hardware set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsr_q <= 4'h0;
    end else begin
      fsr_q <= ((wr_en && sel_debug_fault_status) ? fsr_q & ~pwdata[3:0] : fsr_q)
        | (catch_go ? 4'h8 : 4'h0) | (watch_ev ? 4'h4 : 4'h0);
    end
  end

  // Per-comparator match flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_match <= 32'h0000_0000;
    end else begin
      watch_match <= 32'(hit);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Watch registers read as zero while the unit is disabled
  // Unmapped offsets read as zero
  // The control word reports the comparator count in its top nibble
  wire [31:0] wctl_val = 32'(NCOMP) << vcwu_pkg::VCWU_NUM_POS;
  logic [31:0] cmp_rd;
  always_comb begin
    cmp_rd = 32'h0000_0000;
    for (int i = 0; i < NCOMP; i++) begin
      if (int'(cmp_idx) == i) begin
        cmp_rd = cmp_off[3:2] == 2'd0 ? comp_q[i] :
                 cmp_off[3:2] == 2'd1 ? {27'h0, mask_q[i]} : {28'h0, func_q[i]};
      end
    end
  end
  wire [31:0] rd_val = sel_demc ? demc_q :
                       sel_halt ? {31'h0, debug_en_q} :
                       sel_debug_fault_status ? {28'h0, fsr_q} :
                       (sel_wctl && watch_on) ? wctl_val :
                       (sel_cmp && watch_on) ? cmp_rd : 32'h0000_0000;
  // Read data latched in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_phase && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // All checks run on the bus clock and are off during reset
  // Comparator checks look at the first set, which always exists
  // Function checks hold whatever address is presented
  // Halt checks follow the request from its set to its clear
  // Status checks follow the set bits into the next cycle
  // Control write without a competing local reset
  sequence s_wr_demc;
    wr_en && sel_demc && !local_reset;
  endsequence
  // Armed hard fault event
  sequence s_hf_armed;
    arm_hf && hard_fault_active;
  endsequence
  // Armed local reset event
  sequence s_rst_armed;
    arm_rst && local_reset;
  endsequence
  chk_reset_clears_enable: assert property (@(posedge pclk) disable iff (!presetn)
    local_reset && !(wr_en && sel_demc) |=> !demc_q[vcwu_pkg::VCWU_BIT_WEN] && demc_q[0] == $past(demc_q[0]))
    else $error("local reset enable");
  chk_demc_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_demc |=> demc_q == ($past(pwdata) & vcwu_pkg::VCWU_DEMC_MASK))
    else $error("demc write");
  chk_catch_needs_debug: assert property (@(posedge pclk) disable iff (!presetn)
    !debug_en_q |-> !catch_ev)
    else $error("catch without debug");
  chk_watch_halts: assert property (@(posedge pclk) disable iff (!presetn)
    watch_ev |=> halt_request)
    else $error("watch no halt");
  chk_watch_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !watch_on |-> hit == '0)
    else $error("hit while disabled");
  chk_catch_sets_fsr: assert property (@(posedge pclk) disable iff (!presetn)
    catch_go |=> fsr_q[vcwu_pkg::VCWU_FS_VCATCH] && halt_request)
    else $error("catch status");
  chk_catch_waits_entry: assert property (@(posedge pclk) disable iff (!presetn)
    entry_busy |-> !catch_go)
    else $error("catch during entry");
  chk_hf_catch_pends: assert property (@(posedge pclk) disable iff (!presetn)
    s_hf_armed |=> catch_pend_q)
    else $error("hard fault catch");
  chk_count_field: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && sel_wctl && watch_on |=> prdata[31:28] == 4'(NCOMP))
    else $error("comparator count");
  // Request falls once the core is halted and nothing new arrives
  chk_halt_drops_done: assert property (@(posedge pclk) disable iff (!presetn)
    halt_request && core_halted && !catch_go && !watch_ev |=> !halt_request)
    else $error("halt not dropped");
  // Watch hit records its status bit
  chk_fsr_watch_set: assert property (@(posedge pclk) disable iff (!presetn)
    watch_ev |=> fsr_q[vcwu_pkg::VCWU_FS_WATCH])
    else $error("watch status");
  // Pending catch survives a busy entry
  chk_pend_holds_busy: assert property (@(posedge pclk) disable iff (!presetn)
    catch_pend_q && entry_busy |=> catch_pend_q)
    else $error("pending catch lost");
  // Armed local reset makes a catch pending
  chk_rst_catch_pends: assert property (@(posedge pclk) disable iff (!presetn)
    s_rst_armed |=> catch_pend_q)
    else $error("reset catch");
  // No catch without an enable bit
  chk_catch_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    !demc_q[vcwu_pkg::VCWU_BIT_VCHF] && !demc_q[vcwu_pkg::VCWU_BIT_VCRST] |-> !catch_ev)
    else $error("catch while disarmed");
  // Reserved control bits stay zero
  chk_demc_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (demc_q & ~vcwu_pkg::VCWU_DEMC_MASK) == 32'h0000_0000)
    else $error("reserved bits set");
  // Comparator writes refused while disabled
  chk_watch_wr_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_cmp && !watch_on |=> $stable(comp_q[0]) && $stable(mask_q[0]) && $stable(func_q[0]))
    else $error("write while disabled");
  // Watch registers read zero while disabled
  chk_watch_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_phase && !pwrite && (sel_wctl || sel_cmp) && !watch_on |=> prdata == 32'h0000_0000)
    else $error("read while disabled");
  // Halting debug enable follows its write
  chk_debug_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_halt |=> debug_en_q == $past(pwdata[0]))
    else $error("debug enable write");
  // Local reset keeps the hard fault catch bit
  chk_local_keeps_catch: assert property (@(posedge pclk) disable iff (!presetn)
    local_reset && !(wr_en && sel_demc) |=> demc_q[vcwu_pkg::VCWU_BIT_VCHF] == $past(demc_q[vcwu_pkg::VCWU_BIT_VCHF]))
    else $error("catch bit lost");
  // Catch halts only at the handler
  chk_go_needs_handler: assert property (@(posedge pclk) disable iff (!presetn)
    !handler_first |-> !catch_go)
    else $error("catch before handler");
  // Reserved and disabled codes never match
  chk_reserved_fn_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    func_q[0][3] || func_q[0][3:2] == 2'b00 |-> !hit[0])
    else $error("reserved code match");
  // Instruction match needs a fetch
  chk_pc_needs_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    func_q[0] == vcwu_pkg::VCWU_FN_PC && !iaddr_valid |-> !hit[0])
    else $error("pc match without fetch");
  // Data match needs an access
  chk_rw_needs_access: assert property (@(posedge pclk) disable iff (!presetn)
    func_q[0] == vcwu_pkg::VCWU_FN_RW && !daddr_valid |-> !hit[0])
    else $error("data match without access");
  // Read function ignores writes
  chk_rd_skips_write: assert property (@(posedge pclk) disable iff (!presetn)
    func_q[0] == vcwu_pkg::VCWU_FN_RD && daddr_write |-> !hit[0])
    else $error("read code hit a write");
  // Write function ignores reads
  chk_wr_skips_read: assert property (@(posedge pclk) disable iff (!presetn)
    func_q[0] == vcwu_pkg::VCWU_FN_WR && !daddr_write |-> !hit[0])
    else $error("write code hit a read");
  // Hit shows on the match flags next cycle
  chk_match_follows_hit: assert property (@(posedge pclk) disable iff (!presetn)
    hit[0] |=> watch_match[0])
    else $error("match flag missing");
  // Catch raises the halt request
  chk_catch_go_halts: assert property (@(posedge pclk) disable iff (!presetn)
    catch_go |=> halt_request)
    else $error("catch no halt");
  // A taken catch is no longer pending
  chk_pend_clears_go: assert property (@(posedge pclk) disable iff (!presetn)
    catch_go && !catch_ev |=> !catch_pend_q)
    else $error("catch still pending");
  // Watch enable rises only by a control write
  chk_watch_stays_off: assert property (@(posedge pclk) disable iff (!presetn)
    !watch_on && !(wr_en && sel_demc) |=> !watch_on)
    else $error("watch enable rose");
endmodule
`default_nettype wire

// ### tb/vcwu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module vcwu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic halt_request,
  output logic core_halted
);
  logic [2:0] stay_q; // Cycles left in Debug state
  // ------------------------------
  // Debug state entry and exit
  // ------------------------------
  // Halts one edge after the request, then resumes on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stay_q <= 3'h0;
    end else if (stay_q != 3'h0) begin
      stay_q <= stay_q - 3'h1;
    end else if (halt_request) begin
      stay_q <= 3'h4;
    end
  end
  assign core_halted = (stay_q != 3'h0); // Seen by the block to drop its request
endmodule
`default_nettype wire

// ### tb/vector_catch_and_watchpoint_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module vector_catch_and_watchpoint_unit_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, halt_request, core_halted;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, iaddr = 32'h0, daddr = 32'h0, watch_match, rv;
  logic local_reset = 0, hard_fault_active = 0, handler_first = 0, entry_busy = 0;
  logic iaddr_valid = 0, daddr_valid = 0, daddr_write = 0, er, h;
  logic [1:0] dsize = 2'h2; // Data access size
  int n_mismatch = 0, tests_run = 0, i;
  logic [3:0] fn_tab [8] = '{4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h1, 4'h0}; // Function per case
  int kind_tab [8] = '{0, 0, 1, 2, 2, 2, 1, 1}; // 0 fetch, 1 data read, 2 data write
  logic [31:0] adr_tab [8] = '{32'h0000_100C, 32'h0000_1010, 32'h0000_100C, 32'h0000_100C,
    32'h0000_1008, 32'h0000_1000, 32'h0000_100C, 32'h0000_100C}; // Access address per case
  logic hit_tab [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}; // Expected hit
  // ------------------------------
  // Clock, design and core
  // ------------------------------
  initial begin
    forever #25 pclk = ~pclk;
  end
  vcwu_top #(.NCOMP(2), .MAXMASK(31)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_reset(local_reset), .hard_fault_active(hard_fault_active), .handler_first(handler_first),
    .entry_busy(entry_busy), .iaddr_valid(iaddr_valid), .iaddr(iaddr), .daddr_valid(daddr_valid),
    .daddr_write(daddr_write), .daddr_size(dsize), .daddr(daddr), .core_halted(core_halted),
    .halt_request(halt_request), .watch_match(watch_match));
  vcwu_core_model core_u (.pclk(pclk), .presetn(presetn), .halt_request(halt_request), .core_halted(core_halted));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  // One APB transfer, setup then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      report_and_stop();
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Watches for a halt request over a few cycles
  task automatic see_halt(input int n);
    h = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if (halt_request === 1'b1) h = 1'b1;
    end
  endtask
  // One address strobe, then match flag, halt and status checks
  task automatic probe(input int kind, input logic [31:0] adr, input logic exp);
    @(posedge pclk);
    iaddr_valid <= (kind == 0);
    daddr_valid <= (kind != 0);
    daddr_write <= (kind == 2);
    iaddr <= adr;
    daddr <= adr;
    @(posedge pclk);
    iaddr_valid <= 1'b0;
    daddr_valid <= 1'b0;
    #1;
    chk({31'h0, watch_match[0]}, {31'h0, exp});
    see_halt(3); chk({31'h0, h}, {31'h0, exp});
    apb(0, 12'h008, 0); chk(rv, {29'h0, exp, 2'h0});
    apb(1, 12'h008, 32'hC);
    repeat (6) @(posedge pclk);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); chk(rv, 32'h0);
    apb(1, 12'h020, 32'h0000_1000);
    apb(0, 12'h010, 0); chk(rv, 32'h0);
    apb(1, 12'h000, 32'hFFFF_FFFF);
    apb(0, 12'h000, 0); chk(rv, 32'h0100_0401);
    apb(0, 12'h010, 0); chk(rv, 32'h2000_0000);
    apb(0, 12'h020, 0); chk(rv, 32'h0);
    apb(0, 12'hFFC, 0); chk({31'h0, er}, 32'h1);
    handler_first <= 1'b1;
    local_reset <= 1'b1;
    @(posedge pclk) local_reset <= 1'b0;
    apb(0, 12'h000, 0); chk(rv, 32'h0000_0401);
    hard_fault_active <= 1'b1;
    @(posedge pclk) hard_fault_active <= 1'b0;
    see_halt(6); chk({31'h0, h}, 32'h0);
    apb(1, 12'h004, 32'h1);
    entry_busy <= 1'b1;
    hard_fault_active <= 1'b1;
    @(posedge pclk) hard_fault_active <= 1'b0;
    see_halt(5); chk({31'h0, h}, 32'h0);
    entry_busy <= 1'b0;
    see_halt(3); chk({31'h0, h}, 32'h1);
    apb(0, 12'h008, 0); chk(rv, 32'h8);
    apb(1, 12'h008, 32'hC);
    local_reset <= 1'b1;
    @(posedge pclk) local_reset <= 1'b0;
    see_halt(6); chk({31'h0, h}, 32'h1);
    handler_first <= 1'b0;
    apb(1, 12'h008, 32'hC);
    apb(1, 12'h000, 32'h0100_0000);
    apb(1, 12'h020, 32'h0000_1000);
    apb(1, 12'h024, 32'h4);
    apb(0, 12'h020, 0); chk(rv, 32'h0000_1000);
    for (i = 0; i < 8; i++) begin
      apb(1, 12'h028, {28'h0, fn_tab[i]});
      probe(kind_tab[i], adr_tab[i], hit_tab[i]);
    end
    apb(1, 12'h024, 32'h0);
    apb(1, 12'h020, 32'h0000_1002);
    apb(1, 12'h028, 32'h5);
    probe(1, 32'h0000_1000, 1'b1);
    dsize <= 2'h0;
    probe(1, 32'h0000_1000, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
